// ---- sosr_pkg.sv ----
// Shared constants of the secured OTP and security status logic
package sosr_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] READ_SEC_REG_CMD  = 8'h2B;
  localparam logic [7:0] WRITE_SEC_REG_CMD = 8'h2F;
  localparam logic [7:0] PROT_SEL_CMD      = 8'h68;
  localparam logic [7:0] SINGLE_LOCK_CMD   = 8'h36;
  localparam logic [7:0] SINGLE_UNLOCK_CMD = 8'h39;
  localparam logic [7:0] GANG_LOCK_CMD     = 8'h7E;
  localparam logic [7:0] GANG_UNLOCK_CMD   = 8'h98;
  localparam logic [7:0] PAGE_PROG_CMD     = 8'h02;
  localparam logic [7:0] QUAD_PROG_CMD     = 8'h38;

  // ****************************************
  // Command phase lengths and count ceiling in link clocks
  // ****************************************
  localparam logic [5:0] SPI_CMD_CLKS = 6'h08;
  localparam logic [5:0] QPI_CMD_CLKS = 6'h02;
  localparam logic [5:0] CNT_MAX      = 6'h3F;

  // ****************************************
  // Security register bit positions and reset value
  // ****************************************
  localparam int FACTORY_LOCK_BIT = 0;
  localparam int LOCKDOWN_BIT     = 1;
  localparam int PROG_SUSP_BIT    = 2;
  localparam int ERASE_SUSP_BIT   = 3;
  localparam int RESERVED_BIT     = 4;
  localparam int PROG_FAIL_BIT    = 5;
  localparam int ERASE_FAIL_BIT   = 6;
  localparam int PROT_SEL_BIT     = 7;
  localparam logic [7:0] SREG_RESET = 8'h00;

endpackage : sosr_pkg

// ---- sosr_sync2.sv ----
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/100ps
module sosr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // ****************************************
  // Two flops, first one read only by second
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : sosr_sync2

// ---- sosr_link.sv ----
// Link side: command capture and security register shift-out
`timescale 1ns/100ps
module sosr_link (
  // Link clock, frame and reset
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       rst_n,
  // Mode and register snapshot, static during a frame
  input  wire logic       qpi_i,
  input  wire logic [7:0] sreg_i,
  // Serial lines
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe,
  // Captured command, stable once the frame ends
  output logic      [7:0] op_o,
  output logic      [5:0] cnt_o
);

  logic       fresh_r;
  logic       qpi_s;
  logic [2:0] ph_r;
  logic       cmd_in;

  // Mode is synchronised on the system side; this clock stops between frames
  assign qpi_s = qpi_i;

  // ****************************************
  // Frame start flag
  // ****************************************
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // Opcode and count kept after the frame for the system side
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      op_o  <= 8'h00;
      cnt_o <= 6'h00;
    end else if (fresh_r) begin
      cnt_o <= 6'h01;
      op_o  <= qpi_s ? {4'h0, io_i} : {7'h00, io_i[0]};
    end else begin
      if (cnt_o != sosr_pkg::CNT_MAX) begin
        cnt_o <= cnt_o + 6'h01;
      end
      if (qpi_s && cnt_o < sosr_pkg::QPI_CMD_CLKS) begin
        op_o <= {op_o[3:0], io_i};
      end else if (!qpi_s && cnt_o < sosr_pkg::SPI_CMD_CLKS) begin
        op_o <= {op_o[6:0], io_i[0]};
      end
    end
  end

  assign cmd_in = qpi_s ? (cnt_o >= sosr_pkg::QPI_CMD_CLKS)
                        : (cnt_o >= sosr_pkg::SPI_CMD_CLKS);

  // ****************************************
  // Register out on falling edges, MSB first, repeating
  // ****************************************
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      io_oe <= 4'h0;
      io_o  <= 4'h0;
      ph_r  <= 3'h0;
    end else if (cmd_in && op_o == sosr_pkg::READ_SEC_REG_CMD) begin
      io_oe <= qpi_s ? 4'hF : 4'h2;
      if (qpi_s) begin
        io_o <= ph_r[0] ? sreg_i[3:0] : sreg_i[7:4];
      end else begin
        io_o <= {2'b00, sreg_i[3'h7 - ph_r], 1'b0};
      end
      ph_r <= ph_r + 3'h1;
    end
  end

endmodule : sosr_link

// ---- sosr_top.sv ----
// Secured OTP mode control and security status register
`timescale 1ns/100ps
module sosr_top #(
  parameter logic [7:0] ENTER_OTP_OP   = 8'hB1,
  parameter logic [7:0] EXIT_OTP_OP    = 8'hC1,
  parameter logic [7:0] STATUS_WR_OP   = 8'h01,
  parameter logic [7:0] CHIP_ERASE_OP  = 8'h60,
  parameter logic [7:0] BLOCK_ERASE_OP = 8'hD8,
  parameter logic [7:0] SECT_ERASE_OP  = 8'h20,
  parameter logic [7:0] HALF_ERASE_OP  = 8'h52
) (
  // System clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Link pins
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe,
  input  wire logic       wp_n,
  // Mode from the interface controller
  input  wire logic       qpi_mode,
  // Non-volatile values, sampled once after reset
  input  wire logic       nv_factory_lock,
  input  wire logic       nv_lockdown,
  input  wire logic       nv_prot_sel,
  // Engine status and events
  input  wire logic       prog_susp,
  input  wire logic       erase_susp,
  input  wire logic       prog_fail,
  input  wire logic       prog_pass,
  input  wire logic       erase_fail,
  input  wire logic       erase_pass,
  input  wire logic       prot_sel_done,
  // Decoded command results
  output logic            cmd_valid,
  output logic      [7:0] cmd_code,
  output logic            cmd_refused,
  output logic            lockdown_burn,
  // Access control levels and boot lock pulse
  output logic            otp_mode,
  output logic            array_access_ok,
  output logic            otp_write_ok,
  output logic            all_protect,
  output logic            boot_lock_all,
  output logic      [7:0] sec_reg
);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (ENTER_OTP_OP == EXIT_OTP_OP) begin : g_bad_op
    $error("enter and exit codes must differ");
  end

  // ****************************************
  // Signals
  // ****************************************
  logic       sel_s;
  logic       cs_d_r;
  logic       wprot_s;
  logic       qpi_s;
  logic       frame_end;
  logic [7:0] link_op;
  logic [5:0] link_cnt;
  logic [7:0] snap_r;
  logic       loaded_r;
  logic       lockdown_r;
  logic       factory_r;
  logic       prot_sel_r;
  logic       pfail_r;
  logic       efail_r;
  logic       whole;
  logic       started;
  logic       refuse;

  // Rejected while OTP is being accessed
  function automatic logic otp_blocked(input logic [7:0] op);
    otp_blocked = (op == STATUS_WR_OP)
               || (op == sosr_pkg::WRITE_SEC_REG_CMD)
               || (op == sosr_pkg::PROT_SEL_CMD)
               || (op == sosr_pkg::SINGLE_LOCK_CMD)
               || (op == sosr_pkg::SINGLE_UNLOCK_CMD)
               || (op == sosr_pkg::GANG_LOCK_CMD)
               || (op == sosr_pkg::GANG_UNLOCK_CMD)
               || (op == CHIP_ERASE_OP)
               || (op == BLOCK_ERASE_OP)
               || (op == SECT_ERASE_OP)
               || (op == HALF_ERASE_OP);
  endfunction : otp_blocked

  // Any command that would change stored content
  function automatic logic is_modify(input logic [7:0] op);
    is_modify = otp_blocked(op)
             || (op == sosr_pkg::PAGE_PROG_CMD)
             || (op == sosr_pkg::QUAD_PROG_CMD);
  endfunction : is_modify

  // ****************************************
  // Link domain
  // ****************************************
  // Snapshot is static while a frame runs, so the link reads it safely
  sosr_link u_link (
    .sclk   (sclk),
    .cs_n   (cs_n),
    .rst_n  (rst_n),
    .qpi_i  (qpi_s),
    .sreg_i (snap_r),
    .io_i   (io_i),
    .io_o   (io_o),
    .io_oe  (io_oe),
    .op_o   (link_op),
    .cnt_o  (link_cnt)
  );

  // Select, protect and mode as active-high levels, so reset reads idle
  sosr_sync2 #(.W(3)) u_pin_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .d_i   ({!cs_n, !wp_n, qpi_mode}),
    .q_o   ({sel_s, wprot_s, qpi_s})
  );

  // ****************************************
  // Frame end detection
  // ****************************************
  // Opcode and count are read only after the frame ends: link clock is still
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_d_r <= 1'b1;
    end else begin
      cs_d_r <= !sel_s;
    end
  end

  assign frame_end = !sel_s && !cs_d_r;

  // Exact boundary versus at least a command phase
  assign whole   = qpi_s ? (link_cnt == sosr_pkg::QPI_CMD_CLKS)
                            : (link_cnt == sosr_pkg::SPI_CMD_CLKS);
  assign started = qpi_s ? (link_cnt >= sosr_pkg::QPI_CMD_CLKS)
                            : (link_cnt >= sosr_pkg::SPI_CMD_CLKS);

  // Filtering in OTP mode
  assign refuse = otp_mode && (otp_blocked(link_op)
                  || (lockdown_r && is_modify(link_op)));

  // ****************************************
  // Command result outputs
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid   <= 1'b0;
      cmd_refused <= 1'b0;
      cmd_code    <= 8'h00;
    end else begin
      cmd_valid   <= frame_end && started && !refuse;
      cmd_refused <= frame_end && started && refuse;
      if (frame_end && started) begin
        cmd_code <= link_op;
      end
    end
  end

  // ****************************************
  // OTP mode
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      otp_mode <= 1'b0;
    end else if (frame_end && whole) begin
      if (link_op == ENTER_OTP_OP) begin
        otp_mode <= 1'b1;
      end else if (link_op == EXIT_OTP_OP) begin
        otp_mode <= 1'b0;
      end
    end
  end

  assign array_access_ok = !otp_mode;
  assign otp_write_ok    = otp_mode && !lockdown_r;

  // ****************************************
  // Non-volatile bits
  // ****************************************
  // Stored values are caught by a clocked load just after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_r      <= 1'b0;
      factory_r     <= 1'b0;
      lockdown_r    <= 1'b0;
      prot_sel_r    <= 1'b0;
      lockdown_burn <= 1'b0;
      boot_lock_all <= 1'b0;
    end else begin
      loaded_r      <= 1'b1;
      lockdown_burn <= 1'b0;
      boot_lock_all <= !loaded_r && nv_prot_sel;
      if (!loaded_r) begin
        factory_r  <= nv_factory_lock;
        lockdown_r <= nv_lockdown;
        prot_sel_r <= nv_prot_sel;
      end else begin
        // No write-enable latch is checked here
        if (frame_end && whole && !refuse && !lockdown_r
            && link_op == sosr_pkg::WRITE_SEC_REG_CMD) begin
          lockdown_r    <= 1'b1;
          lockdown_burn <= 1'b1;
        end
        if (prot_sel_done) begin
          prot_sel_r <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Fail flags
  // ****************************************
  // A failure in the same cycle as a pass keeps the flag set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pfail_r <= 1'b0;
      efail_r <= 1'b0;
    end else begin
      if (prog_fail) begin
        pfail_r <= 1'b1;
      end else if (prog_pass) begin
        pfail_r <= 1'b0;
      end
      if (erase_fail) begin
        efail_r <= 1'b1;
      end else if (erase_pass) begin
        efail_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register image and snapshot
  // ****************************************
  always_comb begin
    sec_reg = sosr_pkg::SREG_RESET;
    sec_reg[sosr_pkg::FACTORY_LOCK_BIT] = factory_r;
    sec_reg[sosr_pkg::LOCKDOWN_BIT]     = lockdown_r;
    sec_reg[sosr_pkg::PROG_SUSP_BIT]    = prog_susp;
    sec_reg[sosr_pkg::ERASE_SUSP_BIT]   = erase_susp;
    sec_reg[sosr_pkg::RESERVED_BIT]     = 1'b0;
    sec_reg[sosr_pkg::PROG_FAIL_BIT]    = pfail_r;
    sec_reg[sosr_pkg::ERASE_FAIL_BIT]   = efail_r;
    sec_reg[sosr_pkg::PROT_SEL_BIT]     = prot_sel_r;
  end

  // Frozen while selected; a frame sees the value at its start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= sosr_pkg::SREG_RESET;
    end else if (!sel_s) begin
      snap_r <= sec_reg;
    end
  end

  // Hardware protect in per-block mode
  assign all_protect = prot_sel_r && wprot_s;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_cmd(logic [7:0] op);
    frame_end && whole && link_op == op;
  endsequence

  sequence s_refusable;
    frame_end && started && otp_mode;
  endsequence

  property p_enter;
    @(posedge mclk) disable iff (!rst_n) s_cmd(ENTER_OTP_OP) |=> otp_mode;
  endproperty
  a_enter: assert property (p_enter) else $error("enter missed");

  property p_exit;
    @(posedge mclk) disable iff (!rst_n)
      s_cmd(EXIT_OTP_OP) |=> !otp_mode ##0 array_access_ok;
  endproperty
  a_exit: assert property (p_exit) else $error("exit missed");

  property p_block_sel;
    @(posedge mclk) disable iff (!rst_n)
      s_refusable ##0 link_op == sosr_pkg::SINGLE_LOCK_CMD |=> cmd_refused && !cmd_valid;
  endproperty
  a_block_sel: assert property (p_block_sel) else $error("lock not refused");

  property p_locked_prog;
    @(posedge mclk) disable iff (!rst_n)
      s_refusable ##0 lockdown_r && link_op == sosr_pkg::PAGE_PROG_CMD |=> cmd_refused;
  endproperty
  a_locked_prog: assert property (p_locked_prog) else $error("program passed");

  property p_array;
    @(posedge mclk) disable iff (!rst_n) otp_mode |-> !array_access_ok;
  endproperty
  a_array: assert property (p_array) else $error("array open");

  property p_wr_sets;
    @(posedge mclk) disable iff (!rst_n)
      s_cmd(sosr_pkg::WRITE_SEC_REG_CMD) ##0 !otp_mode && loaded_r && !lockdown_r
      |=> lockdown_r && lockdown_burn ##1 !lockdown_burn;
  endproperty
  a_wr_sets: assert property (p_wr_sets) else $error("lock not set");

  property p_wr_partial;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && !whole && link_op == sosr_pkg::WRITE_SEC_REG_CMD && loaded_r
      |=> $stable(lockdown_r) && !lockdown_burn;
  endproperty
  a_wr_partial: assert property (p_wr_partial) else $error("partial write");

  property p_lock_sticky;
    @(posedge mclk) disable iff (!rst_n) loaded_r && lockdown_r |=> lockdown_r[*3];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

  property p_pfail;
    @(posedge mclk) disable iff (!rst_n)
      prog_fail || (pfail_r && !prog_pass) |=> sec_reg[sosr_pkg::PROG_FAIL_BIT];
  endproperty
  a_pfail: assert property (p_pfail) else $error("program fail lost");

  property p_pfail_clr;
    @(posedge mclk) disable iff (!rst_n)
      prog_pass && !prog_fail |=> !sec_reg[sosr_pkg::PROG_FAIL_BIT];
  endproperty
  a_pfail_clr: assert property (p_pfail_clr) else $error("program fail kept");

  property p_efail;
    @(posedge mclk) disable iff (!rst_n)
      erase_fail ##1 !erase_pass |=> sec_reg[sosr_pkg::ERASE_FAIL_BIT];
  endproperty
  a_efail: assert property (p_efail) else $error("erase fail lost");

  property p_protect;
    @(posedge mclk) disable iff (!rst_n)
      $past(loaded_r) && sec_reg[sosr_pkg::PROT_SEL_BIT] && !$past(wp_n, 2) |-> all_protect;
  endproperty
  a_protect: assert property (p_protect) else $error("not protected");

  property p_sel_sticky;
    @(posedge mclk) disable iff (!rst_n) loaded_r && prot_sel_r |=> prot_sel_r;
  endproperty
  a_sel_sticky: assert property (p_sel_sticky) else $error("select cleared");

  property p_reserved;
    @(posedge mclk) disable iff (!rst_n) sec_reg[sosr_pkg::RESERVED_BIT] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("bit 4 set");

endmodule : sosr_top

// ---- sosr_host.sv ----
// Host link controller model that frames commands on the link pins
`timescale 1ns/100ps
module sosr_host (
  // Link pins towards the block
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] io_i,
  // Answers from the block
  input  wire logic [3:0] io_o,
  input  wire logic [3:0] io_oe
);
  // ****************************************
  // Idle state
  // ****************************************
  // Link clock stands still low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_i = 4'h5;
  end

  // ****************************************
  // Frame
  // ****************************************
  // Command clocks, then read clocks; 30 ns link period
  task automatic frame(input logic qpi, input logic [7:0] op, input int ncmd,
                       input int nrd, output logic [15:0] rd, output logic oe_ok);
    logic [7:0] sh;
    begin
      sh    = op;
      rd    = 16'h0000;
      oe_ok = 1'b1;
      cs_n  = 1'b0;
      for (int i = 0; i < ncmd; i++) begin
        // Upper lines carry noise in single-line mode
        io_i = qpi ? sh[7:4] : {~sh[7], sh[7], ~sh[7], sh[7]};
        sh   = qpi ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
        #15 sclk = 1'b1;
        #15 sclk = 1'b0;
      end
      for (int i = 0; i < nrd; i++) begin
        io_i  = ~io_i;
        #15;
        rd    = qpi ? {rd[11:0], io_o} : {rd[14:0], io_o[1]};
        oe_ok = oe_ok & (io_oe === (qpi ? 4'hF : 4'h2));
        sclk  = 1'b1;
        #15 sclk = 1'b0;
      end
      // Release after a whole number of clocks chosen by the caller
      #15 cs_n = 1'b1;
      io_i = ~io_i;
      #45;
    end
  endtask : frame
endmodule : sosr_host

// ---- tb.sv ----
// Self-checking bench for the secured OTP and security status logic
`timescale 1ns/100ps
module tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic mclk, rst_n, wp_n, qpi_mode, nv_factory_lock, nv_lockdown, nv_prot_sel;
  logic prog_susp, erase_susp, prog_fail, prog_pass, erase_fail, erase_pass, prot_sel_done;
  logic sclk, cs_n, cmd_valid, cmd_refused, lockdown_burn, otp_mode, array_access_ok;
  logic otp_write_ok, all_protect, boot_lock_all;
  logic [3:0]  io_i, io_o, io_oe, ev;
  logic [7:0]  cmd_code, sec_reg;
  logic [15:0] rd;
  int miscompares, total_checks, n_ref, n_burn, n_boot, cycles, base, n_val, vbase;
  localparam logic [7:0] ENT = 8'hB5;
  localparam logic [7:0] EXT = 8'hC5;
  localparam logic [7:0] BLK [11] = '{8'h01, 8'h2F, 8'h68, 8'h36, 8'h39, 8'h7E,
                                      8'h98, 8'h60, 8'hD8, 8'h20, 8'h52};

  // Engine events driven as one vector
  assign {prog_fail, prog_pass, erase_fail, erase_pass} = ev;

  sosr_top #(.ENTER_OTP_OP(ENT), .EXIT_OTP_OP(EXT)) u_dut (
    .mclk, .rst_n, .sclk, .cs_n, .io_i, .io_o, .io_oe, .wp_n, .qpi_mode,
    .nv_factory_lock, .nv_lockdown, .nv_prot_sel, .prog_susp, .erase_susp,
    .prog_fail, .prog_pass, .erase_fail, .erase_pass, .prot_sel_done,
    .cmd_valid, .cmd_code, .cmd_refused, .lockdown_burn, .otp_mode,
    .array_access_ok, .otp_write_ok, .all_protect, .boot_lock_all, .sec_reg
  );

  sosr_host u_host (.sclk, .cs_n, .io_i, .io_o, .io_oe);

  always #5 mclk = ~mclk;

  // Pulse counters and hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cmd_refused === 1'b1) n_ref++;
    if (lockdown_burn === 1'b1) n_burn++;
    if (boot_lock_all === 1'b1) n_boot++;
    if (cmd_valid === 1'b1) n_val++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask : chk

  task automatic step(input int n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask : step

  // Frame, then time for the result pulses to land
  task automatic frm(input logic q, input logic [7:0] op, input int nc, input int nr);
    logic oe_ok;
    begin
      qpi_mode = q;
      // Mode passes two system flops before the link clock starts
      step(3);
      u_host.frame(q, op, nc, nr, rd, oe_ok);
      if (nr > 0) chk(16'(oe_ok), 16'h0001);
      step(6);
    end
  endtask : frm

  task automatic pulse(input logic [3:0] v);
    begin
      ev = v;
      step(1);
      ev = 4'h0;
      step(3);
    end
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_read;
    begin
      chk(16'(sec_reg), 16'h0001);
      chk(16'({otp_mode, array_access_ok}), 16'h0001);
      prog_susp = 1'b1;
      step(4);
      frm(1'b0, sosr_pkg::READ_SEC_REG_CMD, 8, 16);
      chk(rd, 16'h0505);
      prog_susp  = 1'b0;
      erase_susp = 1'b1;
      step(4);
      frm(1'b1, sosr_pkg::READ_SEC_REG_CMD, 2, 4);
      chk(rd, 16'h0909);
      chk(16'(n_val), 16'h0002);
      erase_susp = 1'b0;
      $display("test read done");
    end
  endtask : t_read

  task automatic t_otp;
    begin
      frm(1'b0, ENT, 9, 0);
      chk(16'(otp_mode), 16'h0000);
      frm(1'b0, ENT, 8, 0);
      chk(16'({otp_mode, array_access_ok, otp_write_ok}), 16'h0005);
      base  = n_ref;
      vbase = n_val;
      foreach (BLK[i]) frm(1'b1, BLK[i], 2, 0);
      chk(16'(n_ref - base), 16'd11);
      chk(16'(n_val - vbase), 16'h0000);
      chk({cmd_code, sec_reg}, 16'h5201);
      frm(1'b1, EXT, 2, 0);
      chk(16'({otp_mode, array_access_ok}), 16'h0001);
      $display("test otp done");
    end
  endtask : t_otp

  task automatic t_fail;
    begin
      pulse(4'h8);
      pulse(4'h8);
      chk(16'(sec_reg), 16'h0021);
      pulse(4'h4);
      chk(16'(sec_reg), 16'h0001);
      // Failure and pass in one cycle: the failure wins
      pulse(4'hC);
      chk(16'(sec_reg), 16'h0021);
      pulse(4'h4);
      pulse(4'h3);
      pulse(4'h2);
      chk(16'(sec_reg), 16'h0041);
      pulse(4'h1);
      chk(16'(sec_reg), 16'h0001);
      $display("test fail done");
    end
  endtask : t_fail

  task automatic t_lock;
    begin
      frm(1'b0, sosr_pkg::WRITE_SEC_REG_CMD, 9, 0);
      chk({n_burn[7:0], sec_reg}, 16'h0001);
      frm(1'b1, sosr_pkg::WRITE_SEC_REG_CMD, 2, 0);
      chk({n_burn[7:0], sec_reg}, 16'h0103);
      frm(1'b0, sosr_pkg::WRITE_SEC_REG_CMD, 8, 0);
      chk(16'(n_burn), 16'h0001);
      frm(1'b0, ENT, 8, 0);
      chk(16'({otp_mode, otp_write_ok}), 16'h0002);
      base = n_ref;
      frm(1'b0, sosr_pkg::PAGE_PROG_CMD, 8, 0);
      frm(1'b1, sosr_pkg::QUAD_PROG_CMD, 2, 0);
      frm(1'b0, sosr_pkg::READ_SEC_REG_CMD, 8, 8);
      chk({8'(n_ref - base), rd[7:0]}, 16'h0203);
      frm(1'b0, EXT, 8, 0);
      chk(16'(otp_mode), 16'h0000);
      $display("test lock done");
    end
  endtask : t_lock

  task automatic t_prot;
    begin
      wp_n = 1'b0;
      step(4);
      chk(16'(all_protect), 16'h0000);
      prot_sel_done = 1'b1;
      step(1);
      prot_sel_done = 1'b0;
      step(4);
      chk(16'({sec_reg, all_protect}), 16'h0107);
      wp_n = 1'b1;
      step(4);
      chk(16'(all_protect), 16'h0000);
      // Power cycle with stored protection and lock-down
      nv_factory_lock = 1'b0;
      nv_lockdown     = 1'b1;
      nv_prot_sel     = 1'b1;
      rst_n           = 1'b0;
      step(2);
      rst_n = 1'b1;
      step(4);
      chk({n_boot[7:0], sec_reg}, 16'h0182);
      $display("test protect done");
    end
  endtask : t_prot

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    qpi_mode = 1'b0;
    nv_factory_lock = 1'b1;
    nv_lockdown = 1'b0;
    nv_prot_sel = 1'b0;
    prog_susp = 1'b0;
    erase_susp = 1'b0;
    ev = 4'h0;
    prot_sel_done = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(3);
    t_read();
    t_otp();
    t_fail();
    t_lock();
    t_prot();
    end_sim();
  end
endmodule : tb
